// ---- hw/wdsup_pkg.sv ----
`default_nettype none
package wdsup_pkg;
  // system clock in kHz, used to turn times into cycle counts
  localparam int unsigned CLK_KHZ = 10_000;
  // watchdog periods and nonvolatile store time, in milliseconds
  localparam int unsigned WD_LONG_MS  = 1400;
  localparam int unsigned WD_MID_MS   = 600;
  localparam int unsigned WD_SHORT_MS = 200;
  localparam int unsigned NV_STORE_MS = 10;
  localparam int unsigned WD_LONG_CYC  = WD_LONG_MS * CLK_KHZ;
  localparam int unsigned WD_MID_CYC   = WD_MID_MS * CLK_KHZ;
  localparam int unsigned WD_SHORT_CYC = WD_SHORT_MS * CLK_KHZ;
  localparam int unsigned NV_STORE_CYC = NV_STORE_MS * CLK_KHZ;

  // slave byte: type nibble (value arbitrary), two zero bits, then r/w in bit 0
  localparam logic [3:0] DEV_TYPE   = 4'h5;
  localparam logic [1:0] DEV_ZEROS  = 2'h0;
  // watchdog_config_reg location; the address byte carries the low eight bits
  localparam logic [8:0] CFG_ADDR   = 9'h1ff;
  localparam logic [7:0] TRIP_RAISE_ADDR = 8'h01;
  localparam logic [7:0] TRIP_LOWER_ADDR = 8'h03;
  localparam logic [7:0] TRIP_DATA  = 8'h00;

  // watchdog_config_reg fields
  localparam int unsigned SEL_HI_BIT = 6;
  localparam int unsigned SEL_LO_BIT = 5;
  localparam int unsigned UNLOCK_BIT = 2;
  localparam int unsigned LATCH_BIT  = 1;
  localparam logic [1:0] TSEL_RESET  = 2'h3;
  localparam logic [1:0] TSEL_LONG   = 2'h0;
  localparam logic [1:0] TSEL_MID    = 2'h1;
  localparam logic [1:0] TSEL_SHORT  = 2'h2;
  localparam logic [1:0] TSEL_OFF    = 2'h3;
  localparam logic [7:0] WEL_SET    = 8'h02;
  localparam logic [7:0] WEL_CLR    = 8'h00;
  localparam logic [7:0] UNLOCK_SET = 8'h06;
  localparam logic [7:0] NV_MASK    = 8'h9b;
  localparam logic [7:0] NV_VAL     = 8'h02;

  localparam logic [3:0] ACK_CNT    = 4'h8;

  typedef enum logic [5:0] {
    WDSUP_IDLE  = 6'b00_0001,
    WDSUP_DEV   = 6'b00_0010,
    WDSUP_ADDR  = 6'b00_0100,
    WDSUP_DATA  = 6'b00_1000,
    WDSUP_EXTRA = 6'b01_0000,
    WDSUP_RD    = 6'b10_0000
  } wdsup_link_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } wdsup_wr_t;

  function automatic logic [7:0] wdsup_cfg_byte(input logic [1:0] tsel, input logic unlock, input logic latch);
    wdsup_cfg_byte = 8'h00;
    wdsup_cfg_byte[SEL_HI_BIT] = tsel[1];
    wdsup_cfg_byte[SEL_LO_BIT] = tsel[0];
    wdsup_cfg_byte[UNLOCK_BIT] = unlock;
    wdsup_cfg_byte[LATCH_BIT]  = latch;
  endfunction : wdsup_cfg_byte
endpackage : wdsup_pkg
`default_nettype wire

// ---- hw/wdsup_sync.sv ----
`default_nettype none
module wdsup_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         i_clk,   // destination clock
  input  wire logic         i_nrst,  // async reset, active low
  input  wire logic         i_en,    // clock enable
  input  wire logic [W-1:0] i_d,     // asynchronous levels
  output logic      [W-1:0] o_q      // synchronised levels
);
  logic [W-1:0] meta_q;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      meta_q <= '0;
      o_q    <= '0;
    end else if (i_en) begin
      meta_q <= i_d;
      o_q    <= meta_q;
    end
  end
endmodule : wdsup_sync
`default_nettype wire

// ---- hw/wdsup_ctrl.sv ----
// Notes on behaviour
// - start then stop before timeout restarts watchdog; expiry asserts reset output
// - period from two stored bits; write-protect high blocks changes
// - select 00 long, 01 mid, 10 short, 11 off; 11 after reset
// - 00h to address 01h at programming level, stop, then protect low raises trip
// - 00h to address 03h at programming level, stop, then protect low lowers trip
// - register only via matching slave type at its address, changed only by writes
// - one data byte per write; later bytes get no acknowledge
// - stop after valid store byte starts timed store; bus ignored meanwhile
// - read returns one byte then goes idle without stop
// - write latch clear after reset; while clear, writes other than 02h ignored and data other than 02h or 00h not acknowledged
// - 02h sets latch, 00h clears it, no store cycle
// - store cycle clears the unlock latch
// - third byte with bit 2 set keeps unlock and timeout bits
// - second data byte aborts the write with not-acknowledge
// - reads between steps leave the sequence untouched
// - unlock clears only on store, reset, or protected write attempt
// - start is data falling with clock high, stop data rising with clock high
// - traffic ignored until a start is seen
// - stop after a read leaves the device idle
// - acknowledge slave byte, address byte, written data and read slave byte
// - slave byte is type nibble, two zeros, read bit; acknowledge only on match
// - write-protect high: register write not acknowledged, unlock latch cleared, other bits kept
// - stop before full data byte and acknowledge performs no write
`default_nettype none
module wdsup_ctrl #(
  parameter int unsigned P_WD_LONG_CYC  = wdsup_pkg::WD_LONG_CYC,
  parameter int unsigned P_WD_MID_CYC   = wdsup_pkg::WD_MID_CYC,
  parameter int unsigned P_WD_SHORT_CYC = wdsup_pkg::WD_SHORT_CYC,
  parameter int unsigned P_STORE_CYC    = wdsup_pkg::NV_STORE_CYC
) (
  input  wire logic       i_clock,        // system clock
  input  wire logic       i_nrst,         // async reset, active low
  input  wire logic       i_ce,           // system clock enable
  input  wire logic       i_scl_clk,      // bus clock from the master
  input  wire logic       i_sda_i,        // data line level
  input  wire logic       i_wp,           // write-protect pin level
  input  wire logic       i_wp_prog,      // write-protect at programming level
  output logic            o_sda_o,        // data line drive value (always low)
  output logic            o_sda_oe,       // data line pull-down enable
  output logic            o_wd_rst,       // watchdog reset, active high
  output logic [1:0]      o_timeout_sel,  // stored timeout select
  output logic            o_store_busy,   // nonvolatile store running
  output logic            o_trip_busy,    // trip programming running
  output logic            o_trip_raise,   // pulse: trip raise completed
  output logic            o_trip_lower    // pulse: trip lower completed
);
  localparam int unsigned WCW = $clog2(P_WD_LONG_CYC + 1);
  localparam int unsigned SCW = $clog2(P_STORE_CYC + 1);

  if (P_WD_SHORT_CYC < 2 || P_WD_MID_CYC < P_WD_SHORT_CYC || P_WD_LONG_CYC < P_WD_MID_CYC || P_STORE_CYC < 1) begin
    $error("wdsup_ctrl: period parameters out of order");
  end

  function automatic logic [WCW-1:0] wd_limit(input logic [1:0] sel);
    unique case (sel)
      wdsup_pkg::TSEL_LONG:  wd_limit = WCW'(P_WD_LONG_CYC - 1);
      wdsup_pkg::TSEL_MID:   wd_limit = WCW'(P_WD_MID_CYC - 1);
      wdsup_pkg::TSEL_SHORT: wd_limit = WCW'(P_WD_SHORT_CYC - 1);
      default:               wd_limit = '0;
    endcase
  endfunction : wd_limit

  // ---------------- link side: bus clock domain ----------------
  wdsup_pkg::wdsup_link_t st_q;
  logic [3:0]             bit_cnt_q;
  logic [7:0]             shift_q;
  logic [7:0]             tx_q;
  logic [7:0]             addr_q;
  wdsup_pkg::wdsup_wr_t   wr_q;
  logic                   arm_q;
  logic                   start_ack_q;
  logic                   start_q;
  logic                   start_tgl_q;
  logic                   stop_tgl_q;
  logic                   stop_arm_q;
  logic                   start_new;
  logic [7:0]             cfg_link_q;
  logic                   cfg_seen_q;
  logic                   ack_now;
  logic [3:0]             link_sync;
  logic                   busy_l;
  logic                   wp_l;
  logic                   prog_l;
  logic                   cfg_tgl_l;

  // system-domain registers read by the link side
  logic                   cfg_tgl_q;
  logic [7:0]             cfg_byte;
  logic                   store_busy_q;

  wdsup_sync #(
    .W(4)
  ) u_link_sync (
    .i_clk (i_scl_clk),
    .i_nrst(i_nrst),
    .i_en  (1'b1),
    .i_d   ({store_busy_q, i_wp, i_wp_prog, cfg_tgl_q}),
    .o_q   (link_sync)
  );
  assign {busy_l, wp_l, prog_l, cfg_tgl_l} = link_sync;

  // the clock stands high between frames, so a start after a stop is only
  // visible on the data edge itself, just like the stop
  always_ff @(negedge i_sda_i or negedge i_nrst) begin
    if (!i_nrst) begin
      start_tgl_q <= 1'b0;
    end else if (i_scl_clk) begin
      start_tgl_q <= ~start_tgl_q;
    end
  end

  assign start_new = start_tgl_q != start_ack_q;

  // start flag for the next rising clock edge; data may only move while the clock is low
  always_ff @(negedge i_scl_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      start_q     <= 1'b0;
      start_ack_q <= 1'b0;
    end else begin
      start_q     <= start_new;
      start_ack_q <= start_tgl_q;
    end
  end

  // the armed flag is frozen with the stop, so a frame that follows at once cannot race it
  always_ff @(posedge i_sda_i or negedge i_nrst) begin
    if (!i_nrst) begin
      stop_tgl_q <= 1'b0;
      stop_arm_q <= 1'b0;
    end else if (i_scl_clk) begin
      stop_tgl_q <= ~stop_tgl_q;
      stop_arm_q <= arm_q;
    end
  end

  // register copy for the link side, taken when the system side flags a change
  always_ff @(posedge i_scl_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cfg_link_q <= wdsup_pkg::wdsup_cfg_byte(wdsup_pkg::TSEL_RESET, 1'b0, 1'b0);
      cfg_seen_q <= 1'b0;
    end else if (cfg_tgl_l != cfg_seen_q) begin
      cfg_link_q <= cfg_byte;
      cfg_seen_q <= cfg_tgl_l;
    end
  end

  // acknowledge decision for the ninth clock, from the complete byte in shift_q
  always_comb begin
    ack_now = 1'b0;
    unique case (st_q)
      wdsup_pkg::WDSUP_DEV: begin
        ack_now = shift_q[7:4] == wdsup_pkg::DEV_TYPE && shift_q[3:2] == wdsup_pkg::DEV_ZEROS && !busy_l;
      end
      wdsup_pkg::WDSUP_ADDR: begin
        ack_now = 1'b1;
      end
      wdsup_pkg::WDSUP_DATA: begin
        if (addr_q == wdsup_pkg::CFG_ADDR[7:0]) begin
          ack_now = !wp_l && (cfg_link_q[wdsup_pkg::LATCH_BIT] || shift_q == wdsup_pkg::WEL_SET
                    || shift_q == wdsup_pkg::WEL_CLR);
        end else begin
          ack_now = prog_l && shift_q == wdsup_pkg::TRIP_DATA
                    && (addr_q == wdsup_pkg::TRIP_RAISE_ADDR || addr_q == wdsup_pkg::TRIP_LOWER_ADDR);
        end
      end
      default: ack_now = 1'b0;
    endcase
  end

  // receive and transmit sequencing; bits are sampled on the rising clock edge
  always_ff @(posedge i_scl_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_q      <= wdsup_pkg::WDSUP_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q   <= 8'h00;
      tx_q      <= 8'h00;
      addr_q    <= 8'h00;
      wr_q      <= '0;
      arm_q     <= 1'b0;
    end else if (start_q) begin
      st_q      <= wdsup_pkg::WDSUP_DEV;
      shift_q   <= {shift_q[6:0], i_sda_i};
      bit_cnt_q <= 4'h1;
      arm_q     <= 1'b0;
    end else begin
      unique case (st_q)
        wdsup_pkg::WDSUP_IDLE: begin
          bit_cnt_q <= 4'h0;
        end
        wdsup_pkg::WDSUP_RD: begin
          if (bit_cnt_q != wdsup_pkg::ACK_CNT) begin
            tx_q      <= {tx_q[6:0], 1'b0};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else begin
            st_q      <= wdsup_pkg::WDSUP_IDLE;
            bit_cnt_q <= 4'h0;
          end
        end
        default: begin
          if (bit_cnt_q != wdsup_pkg::ACK_CNT) begin
            shift_q   <= {shift_q[6:0], i_sda_i};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else begin
            bit_cnt_q <= 4'h0;
            unique case (st_q)
              wdsup_pkg::WDSUP_DEV: begin
                if (!ack_now) begin
                  st_q <= wdsup_pkg::WDSUP_IDLE;
                end else if (shift_q[0]) begin
                  st_q <= wdsup_pkg::WDSUP_RD;
                  tx_q <= cfg_link_q;
                end else begin
                  st_q <= wdsup_pkg::WDSUP_ADDR;
                end
              end
              wdsup_pkg::WDSUP_ADDR: begin
                addr_q <= shift_q;
                st_q   <= wdsup_pkg::WDSUP_DATA;
              end
              wdsup_pkg::WDSUP_DATA: begin
                // armed only once the whole byte and its acknowledge slot are through
                wr_q  <= '{addr: addr_q, data: shift_q};
                arm_q <= 1'b1;
                st_q  <= wdsup_pkg::WDSUP_EXTRA;
              end
              default: begin
                arm_q <= 1'b0;
                st_q  <= wdsup_pkg::WDSUP_IDLE;
              end
            endcase
          end
        end
      endcase
    end
  end

  // line drive changes only on the falling clock edge, while the clock is low
  always_ff @(negedge i_scl_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_sda_oe <= 1'b0;
    end else if (start_new) begin
      o_sda_oe <= 1'b0;
    end else if (st_q == wdsup_pkg::WDSUP_RD) begin
      o_sda_oe <= bit_cnt_q != wdsup_pkg::ACK_CNT && !tx_q[7];
    end else begin
      o_sda_oe <= bit_cnt_q == wdsup_pkg::ACK_CNT && ack_now;
    end
  end

  assign o_sda_o = 1'b0;

  // ---------------- system side: i_clock domain ----------------
  logic [4:0]     sys_sync;
  logic           stop_s;
  logic           start_s;
  logic           arm_s;
  logic           wp_s;
  logic           prog_s;
  logic           stop_seen_q;
  logic           start_seen_q;
  logic           stop_ev;
  logic           start_ev;
  logic           frame_q;
  logic [WCW-1:0] wd_cnt_q;
  logic [1:0]     tsel_q;
  logic [1:0]     pend_sel_q;
  logic           latch_q;
  logic           unlock_q;
  logic [SCW-1:0] store_cnt_q;
  logic           store_done;
  logic           commit;
  logic           trip_raise_q;

  wdsup_sync #(
    .W(5)
  ) u_sys_sync (
    .i_clk (i_clock),
    .i_nrst(i_nrst),
    .i_en  (i_ce),
    .i_d   ({stop_tgl_q, start_tgl_q, stop_arm_q, i_wp, i_wp_prog}),
    .o_q   (sys_sync)
  );
  assign {stop_s, start_s, arm_s, wp_s, prog_s} = sys_sync;

  assign stop_ev    = stop_s != stop_seen_q;
  assign start_ev   = start_s != start_seen_q;
  // wr_q is still when the stop arrives: the bus clock has stopped
  assign commit     = stop_ev && arm_s && !store_busy_q;
  assign store_done = store_busy_q && store_cnt_q == SCW'(P_STORE_CYC - 1);
  assign cfg_byte   = wdsup_pkg::wdsup_cfg_byte(tsel_q, unlock_q, latch_q);

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      stop_seen_q  <= 1'b0;
      start_seen_q <= 1'b0;
      frame_q      <= 1'b0;
    end else if (i_ce) begin
      stop_seen_q  <= stop_s;
      start_seen_q <= start_s;
      // both in one cycle: whatever was open stays open
      if (start_ev != stop_ev) begin
        frame_q <= start_ev;
      end
    end
  end

  // the count runs on the system clock, so a silent bus still times out
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      wd_cnt_q <= '0;
      o_wd_rst <= 1'b0;
    end else if (i_ce) begin
      if (tsel_q == wdsup_pkg::TSEL_OFF) begin
        wd_cnt_q <= '0;
        o_wd_rst <= 1'b0;
      end else if (stop_ev && (frame_q || start_ev)) begin
        wd_cnt_q <= '0;
        o_wd_rst <= 1'b0;
      end else if (wd_cnt_q >= wd_limit(tsel_q)) begin
        o_wd_rst <= 1'b1;
      end else begin
        wd_cnt_q <= wd_cnt_q + WCW'(1);
      end
    end
  end

  // timed nonvolatile store
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      store_busy_q <= 1'b0;
      store_cnt_q  <= '0;
      pend_sel_q   <= wdsup_pkg::TSEL_RESET;
    end else if (i_ce) begin
      if (store_busy_q) begin
        store_cnt_q <= store_cnt_q + SCW'(1);
        if (store_done) begin
          store_busy_q <= 1'b0;
        end
      end else if (commit && wr_q.addr == wdsup_pkg::CFG_ADDR[7:0] && !wp_s && latch_q && unlock_q
                   && (wr_q.data & wdsup_pkg::NV_MASK) == wdsup_pkg::NV_VAL
                   && !wr_q.data[wdsup_pkg::UNLOCK_BIT]) begin
        store_busy_q <= 1'b1;
        store_cnt_q  <= '0;
        pend_sel_q   <= {wr_q.data[wdsup_pkg::SEL_HI_BIT], wr_q.data[wdsup_pkg::SEL_LO_BIT]};
      end
    end
  end

  // watchdog_config_reg: timeout select and the two volatile latches
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      tsel_q    <= wdsup_pkg::TSEL_RESET;
      latch_q   <= 1'b0;
      unlock_q  <= 1'b0;
      cfg_tgl_q <= 1'b0;
    end else if (i_ce) begin
      if (store_done) begin
        tsel_q    <= pend_sel_q;
        unlock_q  <= 1'b0;
        cfg_tgl_q <= ~cfg_tgl_q;
      end else if (commit && wr_q.addr == wdsup_pkg::CFG_ADDR[7:0]) begin
        cfg_tgl_q <= ~cfg_tgl_q;
        if (wp_s) begin
          unlock_q <= 1'b0;
        end else if (!latch_q) begin
          latch_q <= wr_q.data == wdsup_pkg::WEL_SET;
        end else if (unlock_q && (wr_q.data & wdsup_pkg::NV_MASK) == wdsup_pkg::NV_VAL) begin
          latch_q <= 1'b1;
        end else if (wr_q.data == wdsup_pkg::WEL_CLR) begin
          latch_q <= 1'b0;
        end else if (wr_q.data == wdsup_pkg::UNLOCK_SET) begin
          unlock_q <= 1'b1;
        end
      end
    end
  end

  // supply trip programming: armed by the stop, finished when protect is low and off the programming level
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_trip_busy  <= 1'b0;
      trip_raise_q <= 1'b0;
      o_trip_raise <= 1'b0;
      o_trip_lower <= 1'b0;
    end else if (i_ce) begin
      o_trip_raise <= 1'b0;
      o_trip_lower <= 1'b0;
      if (o_trip_busy) begin
        if (!wp_s && !prog_s) begin
          o_trip_busy  <= 1'b0;
          o_trip_raise <= trip_raise_q;
          o_trip_lower <= !trip_raise_q;
        end
      end else if (commit && prog_s && wr_q.data == wdsup_pkg::TRIP_DATA
                   && (wr_q.addr == wdsup_pkg::TRIP_RAISE_ADDR || wr_q.addr == wdsup_pkg::TRIP_LOWER_ADDR)) begin
        o_trip_busy  <= 1'b1;
        trip_raise_q <= wr_q.addr == wdsup_pkg::TRIP_RAISE_ADDR;
      end
    end
  end

  assign o_timeout_sel = tsel_q;
  assign o_store_busy  = store_busy_q;
endmodule : wdsup_ctrl
`default_nettype wire

// ---- tb/wdsup_ctrl_asserts.sv ----
`default_nettype none
module wdsup_ctrl_asserts #(
  parameter int unsigned P_STORE_CYC = 20
) (
  input wire logic       i_clock,       // clock
  input wire logic       i_nrst,        // reset
  input wire logic       i_ce,          // enable
  input wire logic       o_sda_o,       // drive value
  input wire logic       o_sda_oe,      // pull enable
  input wire logic       o_wd_rst,      // watchdog reset
  input wire logic [1:0] o_timeout_sel, // select
  input wire logic       o_store_busy,  // store
  input wire logic       o_trip_busy,   // trip pending
  input wire logic       o_trip_raise,  // raise pulse
  input wire logic       o_trip_lower   // lower pulse
);
  timeunit 1ns;
  timeprecision 10ps;
  logic [31:0] busy_cnt_q;
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      busy_cnt_q <= 32'h0000_0000;
    end else if (!o_store_busy) begin
      busy_cnt_q <= 32'h0000_0000;
    end else if (i_ce) begin
      busy_cnt_q <= busy_cnt_q + 32'h0000_0001;
    end
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  sda_low_a: assert property (o_sda_o == 1'b0) else $error("data drive value not low");
  store_len_a: assert property ($fell(o_store_busy) |-> busy_cnt_q == P_STORE_CYC)
    else $error("store length wrong");
  store_max_a: assert property (busy_cnt_q <= P_STORE_CYC) else $error("store too long");
  tsel_hold_a: assert property (o_store_busy && $past(o_store_busy) |-> $stable(o_timeout_sel))
    else $error("select moved during store");
  tsel_src_a: assert property ($changed(o_timeout_sel) |-> $past(o_store_busy) || $past(o_store_busy, 2))
    else $error("select moved without store");
  wd_off_a: assert property (o_timeout_sel == 2'h3 && $past(o_timeout_sel) == 2'h3 |-> !o_wd_rst)
    else $error("reset while watchdog off");
  trip_pulse_a: assert property (o_trip_raise || o_trip_lower |=> !(o_trip_raise || o_trip_lower))
    else $error("trip pulse too long");
  trip_cause_a: assert property (o_trip_raise || o_trip_lower |-> $past(o_trip_busy)
    && !(o_trip_raise && o_trip_lower)) else $error("trip pulse without request");
  store_quiet_a: assert property (o_store_busy && $past(o_store_busy) |-> !o_sda_oe)
    else $error("acknowledge during store");
endmodule : wdsup_ctrl_asserts
bind wdsup_ctrl wdsup_ctrl_asserts #(.P_STORE_CYC(P_STORE_CYC)) u_chk (
  .i_clock(i_clock), .i_nrst(i_nrst), .i_ce(i_ce), .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe),
  .o_wd_rst(o_wd_rst), .o_timeout_sel(o_timeout_sel), .o_store_busy(o_store_busy),
  .o_trip_busy(o_trip_busy), .o_trip_raise(o_trip_raise), .o_trip_lower(o_trip_lower));
`default_nettype wire

// ---- tb/wdsup_host.sv ----
`default_nettype none
module wdsup_host (
  output logic      o_scl,  // bus clock
  output logic      o_sda,  // data drive, high = released
  input  wire logic i_line  // resolved data line
);
  timeunit 1ns;
  timeprecision 10ps;
  // clock idles high between frames, it never runs free
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task automatic start();
    if (!o_scl) begin
      #3.75 o_sda = 1'b1;
      #3.75 o_scl = 1'b1;
    end
    #7.5 o_sda = 1'b0;
    #7.5 o_scl = 1'b0;
  endtask : start
  task automatic stop();
    #3.75 o_sda = 1'b0;
    #3.75 o_scl = 1'b1;
    #7.5 o_sda = 1'b1;
    #7.5;
  endtask : stop
  // data moves only while the clock is low
  task automatic bits(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      #3.75 o_sda = tx[i];
      #3.75 o_scl = 1'b1;
      #1 rx[i] = i_line;
      #6.5 o_scl = 1'b0;
    end
  endtask : bits
  task automatic kick();
    start();
    stop();
  endtask : kick
  task automatic wr(input logic [7:0] s, input logic [7:0] a, input logic [7:0] d, input int nd,
                    output logic [3:0] ack);
    logic [8:0] rx;
    ack = 4'h0;
    start();
    bits({s, 1'b1}, rx);
    ack[3] = !rx[0];
    bits({a, 1'b1}, rx);
    ack[2] = !rx[0];
    for (int i = 0; i < nd; i++) begin
      bits({d, 1'b1}, rx);
      ack[1-i] = !rx[0];
    end
    stop();
  endtask : wr
  task automatic rd(input logic [7:0] s, output logic [7:0] d, output logic [2:0] ack);
    logic [8:0] rx;
    start();
    bits({s, 1'b1}, rx);
    ack[2] = !rx[0];
    bits({wdsup_pkg::CFG_ADDR[7:0], 1'b1}, rx);
    ack[1] = !rx[0];
    start();
    bits({s | 8'h01, 1'b1}, rx);
    ack[0] = !rx[0];
    bits(9'h1ff, rx);
    d = rx[8:1];
    stop();
  endtask : rd
endmodule : wdsup_host
`default_nettype wire

// ---- tb/wdsup_ctrl_test.sv ----
`default_nettype none
module wdsup_ctrl_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] SLV = {wdsup_pkg::DEV_TYPE, wdsup_pkg::DEV_ZEROS, wdsup_pkg::CFG_ADDR[8], 1'b0};
  localparam logic [7:0] ADR = wdsup_pkg::CFG_ADDR[7:0];
  logic       clock = 1'b0, nrst = 1'b0, ce = 1'b1, wp = 1'b0, wpp = 1'b0;
  logic       scl, hsda, sda_o, sda_oe, wd_rst, sbusy, tbusy, traise, tlower;
  logic [1:0] tsel;
  logic [3:0] ack;
  logic [2:0] rack;
  logic [7:0] rdat;
  int         err_total = 0, tests_run = 0;
  wire logic       sda  = hsda & (sda_oe ? sda_o : 1'b1);
  wire logic [7:0] stat = {3'h0, wd_rst, sbusy, tbusy, tsel};
  always #50 clock = ~clock;
  wdsup_host u_host (.o_scl(scl), .o_sda(hsda), .i_line(sda));
  wdsup_ctrl #(.P_WD_LONG_CYC(400), .P_WD_MID_CYC(300), .P_WD_SHORT_CYC(200), .P_STORE_CYC(20)) u_dut (
    .i_clock(clock), .i_nrst(nrst), .i_ce(ce), .i_scl_clk(scl), .i_sda_i(sda), .i_wp(wp), .i_wp_prog(wpp),
    .o_sda_o(sda_o), .o_sda_oe(sda_oe), .o_wd_rst(wd_rst), .o_timeout_sel(tsel), .o_store_busy(sbusy),
    .o_trip_busy(tbusy), .o_trip_raise(traise), .o_trip_lower(tlower));
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask : cyc
  task automatic cfg(input logic [7:0] d, input logic [7:0] exp_ack);
    u_host.wr(SLV, ADR, d, 1, ack);
    chk("write ack", exp_ack, {4'h0, ack});
    cyc(8);
  endtask : cfg
  task automatic rdc(input logic [7:0] mask, input logic [7:0] exp);
    u_host.rd(SLV, rdat, rack);
    chk("read ack", 8'h07, {5'h00, rack});
    chk("read data", exp, rdat & mask);
    cyc(4);
  endtask : rdc
  task automatic store(input logic [7:0] d);
    cfg(d, 8'h0e);
    chk("store busy", 8'h08, stat & 8'h08);
    u_host.wr(SLV, ADR, 8'h02, 1, ack);
    chk("busy ack", 8'h00, {4'h0, ack});
    cyc(30);
  endtask : store
  task automatic t_lock();
    u_host.wr(SLV, ADR, 8'h06, 1, ack);
    chk("locked ack", 8'h0c, {4'h0, ack});
    cfg(8'h02, 8'h0e);
    chk("no cycle", 8'h03, stat);
    rdc(8'hff, 8'h62);
    cfg(8'h00, 8'h0e);
    rdc(8'hff, 8'h60);
    $display("test lock done");
  endtask : t_lock
  task automatic t_wdog(input int lim);
    int n;
    u_host.kick();
    cyc(lim - 8);
    chk("early reset", 8'h00, stat & 8'h10);
    n = 0;
    while (wd_rst !== 1'b1 && n < 16) begin
      cyc(1);
      n++;
    end
    chk("expiry", 8'h10, stat & 8'h10);
    u_host.kick();
    cyc(6);
    chk("restart", 8'h00, stat & 8'h10);
  endtask : t_wdog
  task automatic t_seq();
    for (int i = 0; i < 3; i++) begin
      cfg(8'h02, 8'h0e);
      cfg(8'h06, 8'h0e);
      rdc(8'hff, {1'b0, 2'(3 - i), 5'h06});
      store({1'b0, 2'(2 - i), 5'h02});
      chk("stored", {6'h00, 2'(2 - i)}, stat);
      rdc(8'h64, {1'b0, 2'(2 - i), 5'h00});
      t_wdog(200 + 100 * i);
    end
    $display("test sequence done");
  endtask : t_seq
  task automatic t_prot();
    cfg(8'h02, 8'h0e);
    cfg(8'h06, 8'h0e);
    cfg(8'h06, 8'h0e);
    cyc(30);
    chk("no store", 8'h00, stat & 8'h0b);
    rdc(8'hff, 8'h06);
    wp = 1'b1;
    cyc(4);
    cfg(8'h62, 8'h0c);
    wp = 1'b0;
    cyc(30);
    chk("protected", 8'h00, stat & 8'h0b);
    rdc(8'h64, 8'h00);
    $display("test protect done");
  endtask : t_prot
  task automatic t_abort();
    cfg(8'h02, 8'h0e);
    cfg(8'h06, 8'h0e);
    u_host.wr(SLV, ADR, 8'h22, 2, ack);
    chk("second byte", 8'h0e, {4'h0, ack});
    u_host.wr(SLV, ADR, 8'h22, 0, ack);
    chk("early stop", 8'h0c, {4'h0, ack});
    u_host.wr(SLV ^ 8'h10, ADR, 8'h22, 1, ack);
    chk("bad type", 8'h00, {4'h0, ack});
    u_host.wr(SLV | 8'h04, ADR, 8'h22, 1, ack);
    chk("bad zeros", 8'h00, {4'h0, ack});
    cyc(30);
    chk("aborted", 8'h00, stat & 8'h0b);
    rdc(8'hff, 8'h06);
    store(8'h62);
    chk("off", 8'h03, stat);
    $display("test abort done");
  endtask : t_abort
  task automatic t_trip();
    logic [1:0] seen;
    for (int i = 0; i < 2; i++) begin
      seen = 2'h0;
      wp = 1'b1;
      wpp = 1'b1;
      cyc(4);
      u_host.wr(SLV, 8'(3 - 2 * i), 8'h00, 1, ack);
      chk("trip ack", 8'h0e, {4'h0, ack});
      cyc(8);
      chk("trip busy", 8'h04, stat & 8'h04);
      wp = 1'b0;
      wpp = 1'b0;
      repeat (12) begin
        cyc(1);
        seen = seen | {traise, tlower};
      end
      chk("trip done", {6'h00, 2'(1 + i)}, {6'h00, seen});
    end
    $display("test trip done");
  endtask : t_trip
  // generous span: the whole run needs well under half a millisecond
  initial begin
    #2_000_000;
    err_total++;
    end_sim();
  end
  initial begin
    cyc(20);
    nrst = 1'b1;
    cyc(5);
    chk("reset state", 8'h03, stat);
    t_lock();
    t_seq();
    t_prot();
    t_abort();
    t_trip();
    end_sim();
  end
endmodule : wdsup_ctrl_test
`default_nettype wire
